// ---- rtl/lpr_pkg.sv ----
// Purpose: Shared constants and types for the link parameter register bank.
// Assumes: One 125 MHz clock; all pin inputs are asynchronous to it.
// Notes: Register indices are the byte addresses on the six-bit register port.
package lpr_pkg;
	localparam int CLK_MHZ = 125;
	localparam int MR_MIN_NS = 48;
	localparam int MR_MIN_CYC = (MR_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int SEQ_WIN_CYC = 30;
	localparam logic [4:0] MR_MIN = 5'(MR_MIN_CYC);
	localparam logic [4:0] SEQ_WIN = 5'(SEQ_WIN_CYC);
	localparam logic [14:0] PRESCALE_LAST = 15'h7fff;
	localparam int NPRM = 17;
	localparam int NTMR = 2;
	localparam logic [5:0] IDX_TX_LOOKUP_TABLE_LO = 6'h02;
	localparam logic [5:0] IDX_TX_LOOKUP_TABLE_HI = 6'h03;
	localparam int IDX_RSP_TMR_HI = 7;
	localparam int IDX_MAXLEN_LO = 8;
	localparam int IDX_MAXLEN_HI = 9;
	localparam int IDX_LINK_LO = 10;
	localparam int IDX_LINK_HI = 11;
	localparam int IDX_IDLE_LO = 12;
	localparam int IDX_IDLE_HI = 13;
	localparam int IDX_CMD_ADDR = 14;
	localparam int IDX_RSP_ADDR = 15;
	localparam int IDX_FLAGS = 16;
	localparam logic [5:0] IDX_CMD_REG = 6'h11;
	localparam logic [5:0] IDX_STATUS = 6'h12;
	localparam logic [5:0] IDX_LAST = 6'h1a;
	localparam logic [7:0] CMD_RESET_VAL = 8'h82;
	localparam logic [7:0] PRM_RESET_VAL = 8'h00;
	localparam logic [7:0] FLAGS_MIN = 8'h01;
	localparam int NPIN = 21;
	localparam int PIN_MR = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_RW = 2;
	localparam int PIN_WE = 3;
	localparam int PIN_DS = 4;
	localparam int PIN_RDY = 5;
	localparam int PIN_GNT = 6;
	localparam int PIN_A = 7;
	localparam int PIN_D = 13;
	typedef enum logic [1:0] {RS_IDLE, RS_LOW1, RS_GAP, RS_LOW2} lpr_rseq_t;
	typedef enum logic [1:0] {DM_IDLE, DM_REQ, DM_XFER, DM_END} lpr_dma_t;
endpackage

// ---- rtl/lpr_regs.sv ----
// Purpose: Upper parameter registers, protocol timers, register port, DMA master and reset sequencer.
// Assumes: Pins arrive asynchronously and pass two flops; the DMA client holds its request steady until done.
// Notes: Operation
// Operation
// - Reject frames longer than maximum info length.
// - Send poll command when link check expires.
// - Link check interval is 32768 times parameter.
// - Idle timer interval is 32768 times parameter.
// - Command frames carry the command address byte.
// - Response frames carry the response address byte.
// - At least extra flag count, minimum one.
// - Six address lines bidirectional, decode 27 registers; only 00H to 12H are decoded, the rest read zero.
// - Selected: strobes and address inputs, ready output.
// - DMA masters system memory for tables and data.
// - Pass bus grant along a daisy chain.
// - Master reset low floats every output; bus_req_n is held high and bus_grant_out_n still passes the grant.
// - Master reset clears parameters except table start.
// - Master reset loads command register with 82H.
// - Valid reset pulse is at least six cycles.
// - Glitches under one clock are ignored.
// - One valid pulse selects single-pulse bus convention.
// - Second pulse within thirty cycles selects double-pulse.
// - Second pulse needs six high cycles first.
// - Pulse after the window starts a new sequence.
`timescale 1ns/1ps
module lpr_regs
	import lpr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic master_reset_n,
	input wire logic chip_sel_n,
	input wire logic rw_i,
	output logic rw_o,
	input wire logic write_strobe_n_i,
	output logic write_strobe_n_o,
	input wire logic data_strobe_n_i,
	output logic data_strobe_n_o,
	output logic strobe_oe,
	input wire logic ready_n_i,
	output logic ready_n_o,
	output logic ready_oe,
	input wire logic [5:0] addr_i,
	output logic [5:0] addr_o,
	output logic addr_oe,
	output logic [15:6] addr_hi_o,
	output logic addr_hi_oe,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe,
	output logic bus_req_n,
	input wire logic bus_grant_in_n,
	output logic bus_grant_out_n,
	input wire logic dma_req,
	input wire logic dma_write,
	input wire logic [15:0] dma_addr,
	input wire logic [7:0] dma_wdata,
	output logic [7:0] dma_rdata,
	output logic dma_done,
	input wire logic t1_active,
	input wire logic rx_idle,
	input wire logic [12:0] rx_info_len,
	output logic rx_too_long,
	input wire logic tx_is_command,
	output logic [7:0] tx_address_field,
	output logic [7:0] min_flags,
	output logic send_poll_command,
	output logic idle_timer_expired,
	output logic dual_pulse_mode,
	output logic [7:0] command_reg
);
	typedef struct packed {
		logic [NPIN-1:0] pin_m;
		logic [NPIN-1:0] pin_q;
		logic [NPRM-1:0][7:0] prm;
		logic [7:0] cmd;
		lpr_rseq_t rs;
		logic [4:0] lcnt;
		logic [4:0] hcnt;
		logic dual;
		logic busy;
		logic rd_act;
		logic [7:0] rdata;
		logic [NTMR-1:0][14:0] tpre;
		logic [NTMR-1:0][11:0] tcnt;
		logic [NTMR-1:0] texp;
		logic too_long;
		logic [7:0] afield;
		lpr_dma_t dm;
		logic [7:0] drdata;
		logic ddone;
	} lpr_state_t;

	lpr_state_t st_ff;
	lpr_state_t nxt_st;
	logic mr_low;
	logic sel;
	logic rd_strobe;
	logic wr_strobe;
	logic [5:0] a_q;
	logic [7:0] d_q;
	logic [NTMR-1:0] t_run;
	logic [NTMR-1:0][11:0] t_param;
	logic reset_fire;

	// Glitches shorter than a clock rarely survive two samples, and a surviving one is
	// still far below the six-cycle minimum, so it never counts as a request.
	assign mr_low = !st_ff.pin_q[PIN_MR];
	assign sel = !st_ff.pin_q[PIN_CS] && !mr_low;
	assign a_q = st_ff.pin_q[PIN_A +: 6];
	assign d_q = st_ff.pin_q[PIN_D +: 8];
	// The bus convention chosen at reset decides which strobes mean read and write.
	assign rd_strobe = st_ff.dual ? !st_ff.pin_q[PIN_DS] : (!st_ff.pin_q[PIN_DS] && st_ff.pin_q[PIN_RW]);
	assign wr_strobe = st_ff.dual ? !st_ff.pin_q[PIN_WE] : (!st_ff.pin_q[PIN_DS] && !st_ff.pin_q[PIN_RW]);
	assign t_run[0] = !t1_active;
	assign t_run[1] = rx_idle;
	assign t_param[0] = {st_ff.prm[IDX_LINK_HI][3:0], st_ff.prm[IDX_LINK_LO]};
	assign t_param[1] = {st_ff.prm[IDX_IDLE_HI][3:0], st_ff.prm[IDX_IDLE_LO]};
	assign reset_fire = mr_low && st_ff.lcnt == MR_MIN - 5'h01 &&
		(st_ff.rs == RS_LOW1 || st_ff.rs == RS_LOW2 || st_ff.rs == RS_IDLE);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.pin_m = {data_i, addr_i, bus_grant_in_n, ready_n_i, data_strobe_n_i, write_strobe_n_i,
			rw_i, chip_sel_n, master_reset_n};
		nxt_st.pin_q = st_ff.pin_m;
		nxt_st.ddone = 1'b0;
		nxt_st.texp = '0;

		// Low and high run lengths saturate so long pulses do not wrap.
		if (mr_low) begin
			nxt_st.hcnt = '0;
			if (st_ff.lcnt != SEQ_WIN) begin
				nxt_st.lcnt = st_ff.lcnt + 5'h01;
			end
		end else begin
			nxt_st.lcnt = '0;
			if (st_ff.hcnt != SEQ_WIN) begin
				nxt_st.hcnt = st_ff.hcnt + 5'h01;
			end
		end
		unique case (st_ff.rs)
			RS_IDLE: begin
				if (reset_fire) begin
					nxt_st.rs = RS_LOW1;
				end
			end
			RS_LOW1: begin
				if (!mr_low) begin
					nxt_st.rs = RS_GAP;
					nxt_st.dual = 1'b0;
				end
			end
			RS_GAP: begin
				if (mr_low && st_ff.hcnt < MR_MIN) begin
					nxt_st.hcnt = '0;
				end else if (mr_low) begin
					nxt_st.rs = RS_LOW2;
				end else if (st_ff.hcnt == SEQ_WIN) begin
					nxt_st.rs = RS_IDLE;
				end
			end
			RS_LOW2: begin
				if (!mr_low) begin
					nxt_st.rs = RS_IDLE;
					if (st_ff.lcnt >= MR_MIN) begin
						nxt_st.dual = 1'b1;
					end
				end
			end
		endcase
		if (mr_low && st_ff.rs == RS_LOW2 && st_ff.lcnt == MR_MIN - 5'h01 && st_ff.hcnt == '0) begin
			nxt_st.dual = 1'b1;
		end

		// Register port: one access per strobe, ready held until the strobe is gone.
		if (!(sel && (rd_strobe || wr_strobe))) begin
			nxt_st.busy = 1'b0;
			nxt_st.rd_act = 1'b0;
		end else if (!st_ff.busy) begin
			nxt_st.busy = 1'b1;
			nxt_st.rd_act = rd_strobe;
			nxt_st.rdata = '0;
			if (a_q < 6'(NPRM)) begin
				nxt_st.rdata = st_ff.prm[a_q];
			end else if (a_q == IDX_CMD_REG) begin
				nxt_st.rdata = st_ff.cmd;
			end else if (a_q == IDX_STATUS) begin
				nxt_st.rdata = {6'h00, st_ff.dm != DM_IDLE, st_ff.dual};
			end
			// Reserved bits are stored as written; keeping them zero is software's job.
			if (wr_strobe && a_q < 6'(NPRM)) begin
				nxt_st.prm[a_q] = d_q;
			end else if (wr_strobe && a_q == IDX_CMD_REG) begin
				nxt_st.cmd = d_q;
			end
		end

		for (int i = 0; i < NTMR; i++) begin
			if (!t_run[i] || t_param[i] == '0) begin
				nxt_st.tpre[i] = '0;
				nxt_st.tcnt[i] = t_param[i];
			end else if (st_ff.tpre[i] == PRESCALE_LAST) begin
				nxt_st.tpre[i] = '0;
				if (st_ff.tcnt[i] <= 12'h001) begin
					nxt_st.texp[i] = 1'b1;
					nxt_st.tcnt[i] = t_param[i];
				end else begin
					nxt_st.tcnt[i] = st_ff.tcnt[i] - 12'h001;
				end
			end else begin
				nxt_st.tpre[i] = st_ff.tpre[i] + 15'h0001;
			end
		end

		nxt_st.too_long = rx_info_len > {st_ff.prm[IDX_MAXLEN_HI][4:0], st_ff.prm[IDX_MAXLEN_LO]};
		nxt_st.afield = tx_is_command ? st_ff.prm[IDX_CMD_ADDR] : st_ff.prm[IDX_RSP_ADDR];

		unique case (st_ff.dm)
			DM_IDLE: begin
				// The client sees done one cycle late, so a request still up then is the old one.
				if (dma_req && !mr_low && !st_ff.ddone) begin
					nxt_st.dm = DM_REQ;
				end
			end
			DM_REQ: begin
				if (!st_ff.pin_q[PIN_GNT]) begin
					nxt_st.dm = DM_XFER;
				end
			end
			DM_XFER: begin
				if (!st_ff.pin_q[PIN_RDY]) begin
					nxt_st.drdata = d_q;
					nxt_st.dm = DM_END;
				end
			end
			DM_END: begin
				nxt_st.ddone = 1'b1;
				nxt_st.dm = DM_IDLE;
			end
		endcase

		if (reset_fire) begin
			for (int i = 0; i < NPRM; i++) begin
				if (6'(i) != IDX_TX_LOOKUP_TABLE_LO && 6'(i) != IDX_TX_LOOKUP_TABLE_HI) begin
					nxt_st.prm[i] = PRM_RESET_VAL;
				end
			end
			nxt_st.cmd = CMD_RESET_VAL;
			nxt_st.dm = DM_IDLE;
			nxt_st.busy = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.pin_m <= '1;
			st_ff.pin_q <= '1;
			st_ff.cmd <= CMD_RESET_VAL;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Every driver is gated by the synchronised reset level, so outputs float about two
	// clocks after the pin falls; that lag is the price of a glitch-proof sample.
	assign ready_n_o = !st_ff.busy;
	assign ready_oe = sel;
	assign data_o = (st_ff.dm == DM_IDLE) ? st_ff.rdata : dma_wdata;
	assign data_oe = !mr_low && ((sel && st_ff.busy && st_ff.rd_act) ||
		(st_ff.dm == DM_XFER && dma_write));
	assign addr_o = dma_addr[5:0];
	assign addr_oe = !mr_low && st_ff.dm == DM_XFER;
	assign addr_hi_o = dma_addr[15:6];
	assign addr_hi_oe = addr_oe;
	assign strobe_oe = addr_oe;
	assign rw_o = !dma_write;
	assign data_strobe_n_o = st_ff.dual && dma_write;
	assign write_strobe_n_o = !(st_ff.dual && dma_write);
	assign bus_req_n = mr_low || st_ff.dm == DM_IDLE;
	// A grant this block did not ask for is handed on to the next controller.
	assign bus_grant_out_n = st_ff.pin_q[PIN_GNT] || st_ff.dm != DM_IDLE;
	assign dma_rdata = st_ff.drdata;
	assign dma_done = st_ff.ddone;
	assign rx_too_long = st_ff.too_long;
	assign tx_address_field = st_ff.afield;
	assign min_flags = (st_ff.prm[IDX_FLAGS] == '0) ? FLAGS_MIN : st_ff.prm[IDX_FLAGS];
	assign send_poll_command = st_ff.texp[0];
	assign idle_timer_expired = st_ff.texp[1];
	assign dual_pulse_mode = st_ff.dual;
	assign command_reg = st_ff.cmd;

	a_float_in_reset: assert property (@(posedge clk) disable iff (!rst_n)
		mr_low |-> !data_oe && !ready_oe && !addr_oe && bus_req_n) else $error("driving in reset");
	a_reset_clears: assert property (@(posedge clk) disable iff (!rst_n)
		reset_fire |=> st_ff.cmd == CMD_RESET_VAL && st_ff.prm[IDX_FLAGS] == '0) else $error("bad reset");
	a_tx_lookup_table_kept: assert property (@(posedge clk) disable iff (!rst_n)
		reset_fire && !st_ff.busy |=> $stable(st_ff.prm[IDX_TX_LOOKUP_TABLE_LO])) else $error("table lost");
	a_short_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(mr_low) ##1 !mr_low |-> !$past(reset_fire)) else $error("short pulse taken");
	a_flag_floor: assert property (@(posedge clk) disable iff (!rst_n)
		min_flags != '0 && min_flags >= st_ff.prm[IDX_FLAGS]) else $error("flag floor");
	a_poll_gated: assert property (@(posedge clk) disable iff (!rst_n)
		send_poll_command |-> !$past(t1_active)) else $error("poll while t1 runs");
	a_len_check: assert property (@(posedge clk) disable iff (!rst_n)
		rx_too_long |-> $past(rx_info_len) > $past({st_ff.prm[IDX_MAXLEN_HI][4:0], st_ff.prm[IDX_MAXLEN_LO]}))
		else $error("false reject");
	a_grant_pass: assert property (@(posedge clk) disable iff (!rst_n)
		st_ff.dm == DM_IDLE && !st_ff.pin_q[PIN_GNT] |-> !bus_grant_out_n) else $error("grant held");
	a_mode_single: assert property (@(posedge clk) disable iff (!rst_n)
		st_ff.rs == RS_LOW1 && !mr_low |=> !dual_pulse_mode) else $error("mode not single");
	c_dual_mode: cover property (@(posedge clk) disable iff (!rst_n) $rose(dual_pulse_mode));
	c_poll: cover property (@(posedge clk) disable iff (!rst_n) send_poll_command);
	c_dma: cover property (@(posedge clk) disable iff (!rst_n) dma_done && !dma_write);
endmodule

// ---- test/lpr_mem.sv ----
// Purpose: Memory and bus arbiter on the far side of the DMA port.
// Assumes: Grant follows request; ready comes dly+1 cycles after the address is enabled.
// Notes: Undriven read data toggles so a stale value cannot match.
`timescale 1ns/1ps
module lpr_mem (
	input wire logic clk,
	input wire logic req_n,
	input wire logic chain,
	input wire logic oe,
	input wire logic [15:0] ad,
	input wire logic rd,
	input wire logic [7:0] wd,
	input wire logic [3:0] dly,
	output logic gnt_n = 1,
	output logic rdy_n = 1,
	output logic [7:0] q = 0,
	output logic drv = 0
);
	logic [7:0] m [0:255];
	logic [3:0] c = 0;
	always @(posedge clk) begin
		gnt_n <= req_n && !chain;
		if (!oe) begin
			c <= 0;
			rdy_n <= 1;
			drv <= 0;
			q <= ~q;
		end else if (rdy_n) begin
			c <= c + 1;
			if (c == dly) begin
				rdy_n <= 0;
				drv <= rd;
				q <= m[ad[7:0]];
				if (!rd) m[ad[7:0]] <= wd;
			end
		end
	end
endmodule

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the link parameter register bank.
// Assumes: Single-pulse bus after power-on; the memory model answers DMA.
// Notes: The timer scenario dominates the run, about 66000 cycles.
`timescale 1ns/1ps
module tb;
	import lpr_pkg::*;
	logic clk = 0, rst_n = 0, master_reset_n = 1, chip_sel_n = 1, rw_i = 1;
	logic write_strobe_n_i = 1, data_strobe_n_i = 1, ready_n_i, bus_grant_in_n;
	logic dma_req = 0, dma_write = 0, t1_active = 1, rx_idle = 0, tx_is_command = 0;
	logic [5:0] addr_i = 0, addr_o;
	logic [7:0] data_i, hd = 0, dma_wdata = 0, q, rv;
	logic [15:0] dma_addr = 0;
	logic [12:0] rx_info_len = 0;
	logic rw_o, write_strobe_n_o, data_strobe_n_o, strobe_oe, ready_n_o, ready_oe, addr_oe;
	logic addr_hi_oe, data_oe, bus_req_n, bus_grant_out_n, dma_done, rx_too_long;
	logic send_poll_command, idle_timer_expired, dual_pulse_mode, drv, chain = 0, dual = 0;
	logic [15:6] addr_hi_o;
	logic [7:0] data_o, dma_rdata, tx_address_field, min_flags, command_reg;
	logic [3:0] dly = 0;
	logic [31:0] seed = 32'h8c39718c;
	int mismatches = 0, total_checks = 0, mdl [0:63], i, k, n, it;
	int lq [$];
	always #4 clk = ~clk;
	assign data_i = drv ? q : hd;
	lpr_regs dut (.clk, .rst_n, .master_reset_n, .chip_sel_n, .rw_i, .rw_o, .write_strobe_n_i,
		.write_strobe_n_o, .data_strobe_n_i, .data_strobe_n_o, .strobe_oe, .ready_n_i, .ready_n_o,
		.ready_oe, .addr_i, .addr_o, .addr_oe, .addr_hi_o, .addr_hi_oe, .data_i, .data_o, .data_oe,
		.bus_req_n, .bus_grant_in_n, .bus_grant_out_n, .dma_req, .dma_write, .dma_addr, .dma_wdata,
		.dma_rdata, .dma_done, .t1_active, .rx_idle, .rx_info_len, .rx_too_long, .tx_is_command,
		.tx_address_field, .min_flags, .send_poll_command, .idle_timer_expired, .dual_pulse_mode,
		.command_reg);
	lpr_mem mem (.clk, .req_n(bus_req_n), .chain, .oe(addr_oe), .ad({addr_hi_o, addr_o}), .rd(rw_o),
		.wd(data_o), .dly, .gnt_n(bus_grant_in_n), .rdy_n(ready_n_i), .q, .drv);
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	task automatic final_report();
		if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	// A wait that runs out is a hang in the design, so the run stops there.
	task automatic wt(ref logic s, input logic v);
		int j;
		for (j = 0; j < 80 && s !== v; j++) @(negedge clk);
		if (s !== v) begin
			mismatches++;
			final_report();
		end
	endtask
	task automatic acc(input logic w, input int a, input logic [7:0] d);
		@(posedge clk);
		chip_sel_n <= 0;
		addr_i <= 6'(a);
		hd <= d;
		rw_i <= !w;
		if (dual && w) write_strobe_n_i <= 0;
		else data_strobe_n_i <= 0;
		wt(ready_n_o, 0);
		rv = data_o;
		@(posedge clk);
		write_strobe_n_i <= 1;
		data_strobe_n_i <= 1;
		hd <= ~d;
		wt(ready_n_o, 1);
		@(posedge clk);
		chip_sel_n <= 1;
	endtask
	task automatic wr(input int a, input logic [7:0] d);
		acc(1, a, d);
		if (a < 17) mdl[a] = d;
	endtask
	task automatic rdc(input int a);
		acc(0, a, 0);
		chk(rv, mdl[a]);
	endtask
	// Chip select is held low so that a floated ready driver shows.
	task automatic mrp(input int lo, input int hi);
		@(posedge clk);
		master_reset_n <= 0;
		chip_sel_n <= 0;
		repeat (lo) @(negedge clk);
		if (lo > 5) chk({ready_oe, data_oe, strobe_oe, addr_oe, addr_hi_oe}, 0);
		@(posedge clk);
		master_reset_n <= 1;
		chip_sel_n <= 1;
		repeat (hi) @(posedge clk);
	endtask
	task automatic dma(input logic w, input int a, input logic [7:0] d);
		@(posedge clk);
		dma_req <= 1;
		dma_write <= w;
		dma_addr <= 16'(a);
		dma_wdata <= d;
		wt(dma_done, 1);
		@(posedge clk);
		dma_req <= 0;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		repeat (4) @(posedge clk);
		for (i = 0; i < 64; i++) mdl[i] = (i == 17) ? 'h82 : 0;
		for (i = 0; i < 20; i++) rdc(i);
		chk(command_reg, 8'h82);
		chk(bus_req_n, 1);
		for (i = 0; i < 17; i++) wr(i, rnd() & ((i % 2 && i > 6 && i < 14) ? 8'h0f : 8'hff));
		wr(40, rnd());
		for (i = 0; i < 17; i++) rdc(i);
		rdc(40);
		wr(16, 0);
		chk(min_flags, 1);
		wr(16, 8'h07);
		chk(min_flags, 7);
		for (k = 0; k < 2; k++) begin
			@(posedge clk);
			rx_info_len <= 13'({mdl[9][4:0], mdl[8][7:0]} + k);
			tx_is_command <= k[0];
			repeat (3) @(negedge clk);
			chk(rx_too_long, k);
			chk(tx_address_field, mdl[15 - k]);
		end
		for (k = 0; k < 2; k++) begin
			dly <= 4'(k * 5);
			dma(1, 16'h0130 + k, 8'h5a ^ 8'(k));
			dma(0, 16'h0130 + k, 0);
			chk(dma_rdata, 8'h5a ^ 8'(k));
		end
		@(posedge clk);
		chain <= 1;
		wt(bus_grant_out_n, 0);
		@(posedge clk);
		chain <= 0;
		wr(10, 1);
		wr(11, 0);
		wr(12, 2);
		wr(13, 0);
		@(posedge clk);
		t1_active <= 0;
		rx_idle <= 1;
		it = 0;
		for (n = 1; n < 66000; n++) begin
			@(negedge clk);
			if (send_poll_command === 1'b1) lq.push_back(n);
			if (idle_timer_expired === 1'b1 && it == 0) it = n;
		end
		chk(lq[0] > 32760 && lq[0] < 32776 && lq[1] - lq[0] == 32768, 1);
		chk(it > 65530 && it < 65542, 1);
		@(posedge clk);
		t1_active <= 1;
		rx_idle <= 0;
		mrp(8, 40);
		chk(dual_pulse_mode, 0);
		for (i = 0; i < 64; i++) mdl[i] = (i == 17) ? 'h82 : (i == 2 || i == 3) ? mdl[i] : 0;
		for (i = 0; i < 19; i++) rdc(i);
		wr(14, 8'ha5);
		mrp(3, 40);
		rdc(14);
		mrp(8, 10);
		mrp(8, 40);
		chk(dual_pulse_mode, 1);
		dual = 1;
		wr(15, 8'h3c);
		rdc(15);
		dual = 0;
		mrp(8, 3);
		mrp(8, 40);
		chk(dual_pulse_mode, 0);
		mrp(8, 40);
		mrp(8, 40);
		chk(dual_pulse_mode, 0);
		final_report();
	end
endmodule
